// >>> rtl/subdec_map.svh
// constants for the subtract-with-borrow and decrement-skip datapath
`ifndef SUBDEC_MAP_SVH
`define SUBDEC_MAP_SVH

`define DATA_W        8
`define OPC_W         2
`define OPC_NONE      2'h0
`define OPC_SBC_ACC   2'h1
`define OPC_SBC_MEM   2'h2
`define OPC_DEC_SKIP  2'h3
`define DATA_ZERO     8'h00
`define DATA_ONE      8'h01
`define ST_IDLE       2'h0
`define ST_RESULT     2'h1
`define ST_DUMMY      2'h3

`endif

// >>> rtl/subdec_pkg.sv
// types shared by the subtract-with-borrow and decrement-skip datapath
`include "subdec_map.svh"

package subdec_pkg;

   typedef logic [`DATA_W-1:0] byte_t;

   typedef enum logic [1:0] {
      ST_IDLE   = `ST_IDLE,
      ST_RESULT = `ST_RESULT,
      ST_DUMMY  = `ST_DUMMY
   } exec_state_t;

   typedef struct packed {
      exec_state_t state;
      logic        acc_we;
      logic        mem_we;
      logic        flag_we;
      byte_t       acc_out;
      byte_t       mem_out;
      logic        carry;
      logic        zero;
      logic        overflow_flag;
      logic        aux_carry_flag;
      logic        skip;
      logic        dummy;
      logic        done;
   } exec_regs_t;

endpackage

// >>> rtl/sub_borrow_alu.sv
// combinational subtract-with-borrow and decrement arithmetic
`timescale 1ns/10ps
`include "subdec_map.svh"

module sub_borrow_alu
   import subdec_pkg::*;
#(
   parameter int W = `DATA_W
) (
   // operands
   input  wire logic [W-1:0] acc,
   input  wire logic [W-1:0] mem,
   input  wire logic         carry_in,
   // subtract results
   output logic      [W-1:0] diff,
   output logic              carry_out,
   output logic              zero,
   output logic              overflow_flag,
   output logic              aux_carry_flag,
   // decrement result
   output logic      [W-1:0] dec
);

   logic [W:0] wide;
   logic [4:0] low;

   always_comb begin
      // carry clear means a borrow was taken
      wide           = {1'b0, acc} - {1'b0, mem} - {{W{1'b0}}, ~carry_in};
      low            = {1'b0, acc[3:0]} - {1'b0, mem[3:0]} - {4'h0, ~carry_in};
      diff           = wide[W-1:0];
      carry_out      = ~wide[W];
      zero           = (wide[W-1:0] == '0);
      overflow_flag  = (acc[W-1] ^ mem[W-1]) & (acc[W-1] ^ wide[W-1]);
      aux_carry_flag = ~low[4];
      dec            = mem - W'(1);
   end

endmodule

// >>> rtl/sub_borrow_dec_skip.sv
// execution datapath for subtract-with-borrow and decrement-skip-if-zero
`timescale 1ns/10ps
`include "subdec_map.svh"

module sub_borrow_dec_skip
   import subdec_pkg::*;
#(
   parameter int W = `DATA_W
) (
   // clock and reset
   input  wire logic             CORE_CLK,
   input  wire logic             RST_N,
   // request from sequencer
   input  wire logic             OP_VALID,
   input  wire logic [`OPC_W-1:0] OP_CODE,
   output logic                  OP_READY,
   // operands
   input  wire logic [W-1:0]     ACC_IN,
   input  wire logic [W-1:0]     MEM_IN,
   input  wire logic             CARRY_IN,
   // accumulator write
   output logic                  ACC_WE,
   output logic      [W-1:0]     ACC_OUT,
   // data memory write
   output logic                  MEM_WE,
   output logic      [W-1:0]     MEM_OUT,
   // status flags
   output logic                  FLAG_WE,
   output logic                  C_OUT,
   output logic                  Z_OUT,
   output logic                  OV_OUT,
   output logic                  AC_OUT,
   // sequencing
   output logic                  SKIP,
   output logic                  DUMMY_CYCLE,
   output logic                  DONE
);

   function automatic logic is_sub(input logic [`OPC_W-1:0] op);
      is_sub = (op == `OPC_SBC_ACC) || (op == `OPC_SBC_MEM);
   endfunction

   exec_regs_t r;
   exec_regs_t next_r;

   logic [W-1:0] diff;
   logic [W-1:0] dec;
   logic         c_new;
   logic         z_new;
   logic         ov_new;
   logic         ac_new;
   logic         take;

   sub_borrow_alu #(
      .W(W)
   ) u_alu (
      .acc           (ACC_IN),
      .mem           (MEM_IN),
      .carry_in      (CARRY_IN),
      .diff          (diff),
      .carry_out     (c_new),
      .zero          (z_new),
      .overflow_flag (ov_new),
      .aux_carry_flag(ac_new),
      .dec           (dec)
   );

   assign OP_READY = (r.state == ST_IDLE);
   assign take     = OP_VALID && OP_READY && (OP_CODE != `OPC_NONE);

   always_comb begin
      next_r         = r;
      next_r.acc_we  = 1'b0;
      next_r.mem_we  = 1'b0;
      next_r.flag_we = 1'b0;
      next_r.skip    = 1'b0;
      next_r.dummy   = 1'b0;
      next_r.done    = 1'b0;
      case (r.state)
         ST_IDLE: begin
            if (take) begin
               next_r.state = ST_RESULT;
               next_r.done  = 1'b1;
               if (is_sub(OP_CODE)) begin
                  // both subtract forms update all four flags
                  next_r.flag_we        = 1'b1;
                  next_r.carry          = c_new;
                  next_r.zero           = z_new;
                  next_r.overflow_flag  = ov_new;
                  next_r.aux_carry_flag = ac_new;
               end
               case (OP_CODE)
                  `OPC_SBC_ACC: begin
                     next_r.acc_we  = 1'b1;
                     next_r.acc_out = diff;
                  end
                  `OPC_SBC_MEM: begin
                     next_r.mem_we  = 1'b1;
                     next_r.mem_out = diff;
                  end
                  `OPC_DEC_SKIP: begin
                     next_r.mem_we  = 1'b1;
                     next_r.mem_out = dec;
                     next_r.skip    = (dec == `DATA_ZERO);
                  end
                  default: begin
                     next_r.state = ST_IDLE;
                  end
               endcase
            end
         end
         ST_RESULT: begin
            // a taken skip spends one more cycle on the dummy slot
            if (r.skip) begin
               next_r.state = ST_DUMMY;
               next_r.dummy = 1'b1;
            end else begin
               next_r.state = ST_IDLE;
            end
         end
         ST_DUMMY: begin
            next_r.state = ST_IDLE;
         end
         default: begin
            next_r.state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         r.state          <= ST_IDLE;
         r.acc_we         <= 1'b0;
         r.mem_we         <= 1'b0;
         r.flag_we        <= 1'b0;
         r.acc_out        <= `DATA_ZERO;
         r.mem_out        <= `DATA_ZERO;
         r.carry          <= 1'b0;
         r.zero           <= 1'b0;
         r.overflow_flag  <= 1'b0;
         r.aux_carry_flag <= 1'b0;
         r.skip           <= 1'b0;
         r.dummy          <= 1'b0;
         r.done           <= 1'b0;
      end else begin
         r <= next_r;
      end
   end

   assign ACC_WE      = r.acc_we;
   assign ACC_OUT     = r.acc_out;
   assign MEM_WE      = r.mem_we;
   assign MEM_OUT     = r.mem_out;
   assign FLAG_WE     = r.flag_we;
   assign C_OUT       = r.carry;
   assign Z_OUT       = r.zero;
   assign OV_OUT      = r.overflow_flag;
   assign AC_OUT      = r.aux_carry_flag;
   assign SKIP        = r.skip;
   assign DUMMY_CYCLE = r.dummy;
   assign DONE        = r.done;

   // checks
   default clocking cb @(posedge CORE_CLK);
   endclocking
   default disable iff (!RST_N);

   sequence seq_take_acc;
      take && (OP_CODE == `OPC_SBC_ACC);
   endsequence

   sequence seq_take_mem;
      take && (OP_CODE == `OPC_SBC_MEM);
   endsequence

   sequence seq_take_dec;
      take && (OP_CODE == `OPC_DEC_SKIP);
   endsequence

   sequence seq_skip_tail;
      SKIP && !OP_READY ##1 DUMMY_CYCLE && !OP_READY ##1 OP_READY && !DUMMY_CYCLE;
   endsequence

   chk_acc_diff_value: assert property (
      seq_take_acc |=> ACC_WE && !MEM_WE
         && ACC_OUT == W'($past(ACC_IN) - $past(MEM_IN) - W'(!$past(CARRY_IN))))
      else $error("accumulator difference wrong");

   chk_carry_sign: assert property (
      (take && is_sub(OP_CODE)) |=> FLAG_WE
         && C_OUT == ({1'b0, $past(ACC_IN)} >= ({1'b0, $past(MEM_IN)}
                      + {{W{1'b0}}, !$past(CARRY_IN)})))
      else $error("carry flag does not follow borrow");

   chk_zero_flag: assert property (
      seq_take_acc |=> Z_OUT == (ACC_OUT == `DATA_ZERO))
      else $error("zero flag disagrees with result");

   chk_mem_diff_value: assert property (
      seq_take_mem |=> MEM_WE && !ACC_WE
         && MEM_OUT == W'($past(ACC_IN) - $past(MEM_IN) - W'(!$past(CARRY_IN))))
      else $error("memory difference wrong");

   chk_dec_writeback: assert property (
      seq_take_dec |=> MEM_WE && !ACC_WE && !FLAG_WE
         && MEM_OUT == W'($past(MEM_IN) - W'(1)) && $stable(C_OUT) && $stable(Z_OUT)
         && $stable(OV_OUT) && $stable(AC_OUT))
      else $error("decrement write-back wrong or flags touched");

   chk_skip_taken: assert property (
      (seq_take_dec and (MEM_IN == `DATA_ONE)) |=> seq_skip_tail)
      else $error("zero decrement did not skip with dummy cycle");

   chk_no_skip: assert property (
      (seq_take_dec and (MEM_IN != `DATA_ONE)) |=> !SKIP ##1 OP_READY && !DUMMY_CYCLE)
      else $error("nonzero decrement skipped");

   chk_busy_refuse: assert property (
      (DONE || DUMMY_CYCLE) |-> !OP_READY)
      else $error("ready while instruction still executing");

   chk_busy_no_take: assert property (
      (OP_VALID && !OP_READY) |=> !DONE && !ACC_WE && !MEM_WE)
      else $error("request taken while instruction still executing");

endmodule

// >>> dv/store_model.sv
// accumulator and data memory byte behind the datapath, with write counters
`timescale 1ns/10ps

module store_model
   import subdec_pkg::*;
(
   // clock and reset
   input  wire logic  clk,
   input  wire logic  rst_n,
   // writes from the datapath
   input  wire logic  acc_we,
   input  wire byte_t acc_out,
   input  wire logic  mem_we,
   input  wire byte_t mem_out,
   input  wire logic  flag_we,
   // stored state
   output byte_t      acc,
   output byte_t      mem,
   output int         n_acc,
   output int         n_mem,
   output int         n_flag
);
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         acc <= 8'h00;
         mem <= 8'h00;
         n_acc <= 0;
         n_mem <= 0;
         n_flag <= 0;
      end else begin
         if (acc_we) begin
            acc <= acc_out;
            n_acc <= n_acc + 1;
         end
         if (mem_we) begin
            mem <= mem_out;
            n_mem <= n_mem + 1;
         end
         if (flag_we) begin
            n_flag <= n_flag + 1;
         end
      end
   end
endmodule

// >>> dv/testbench.sv
// self-checking bench for the subtract-with-borrow and decrement-skip datapath
`timescale 1ns/10ps
`include "subdec_map.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fails++; \
   $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end

module testbench
   import subdec_pkg::*;
;
   logic       CORE_CLK, RST_N, OP_VALID, CARRY_IN, OP_READY, ACC_WE, MEM_WE;
   logic       FLAG_WE, C_OUT, Z_OUT, OV_OUT, AC_OUT, SKIP, DUMMY_CYCLE, DONE;
   logic [1:0] OP_CODE;
   byte_t      ACC_IN, MEM_IN, ACC_OUT, MEM_OUT, acc_s, mem_s;
   int         fails, tests_run, n_acc, n_mem, n_flag;

   sub_borrow_dec_skip i_sub_borrow_dec_skip (.CORE_CLK(CORE_CLK), .RST_N(RST_N),
      .OP_VALID(OP_VALID), .OP_CODE(OP_CODE), .OP_READY(OP_READY), .ACC_IN(ACC_IN),
      .MEM_IN(MEM_IN), .CARRY_IN(CARRY_IN), .ACC_WE(ACC_WE), .ACC_OUT(ACC_OUT),
      .MEM_WE(MEM_WE), .MEM_OUT(MEM_OUT), .FLAG_WE(FLAG_WE), .C_OUT(C_OUT),
      .Z_OUT(Z_OUT), .OV_OUT(OV_OUT), .AC_OUT(AC_OUT), .SKIP(SKIP),
      .DUMMY_CYCLE(DUMMY_CYCLE), .DONE(DONE));

   store_model i_store_model (.clk(CORE_CLK), .rst_n(RST_N), .acc_we(ACC_WE),
      .acc_out(ACC_OUT), .mem_we(MEM_WE), .mem_out(MEM_OUT), .flag_we(FLAG_WE),
      .acc(acc_s), .mem(mem_s), .n_acc(n_acc), .n_mem(n_mem), .n_flag(n_flag));

   // {c, z, ov, ac, result}
   function automatic logic [11:0] ref_sub(byte_t a, byte_t m, logic c);
      logic [8:0] d;
      logic [4:0] n;
      d = {1'b0, a} - {1'b0, m} - {8'h00, ~c};
      n = {1'b0, a[3:0]} - {1'b0, m[3:0]} - {4'h0, ~c};
      return {~d[8], d[7:0] == 8'h00, (a[7] ^ m[7]) & (d[7] ^ a[7]), ~n[4], d[7:0]};
   endfunction

   task automatic exec(logic [1:0] op, byte_t a, byte_t m, logic c);
      @(posedge CORE_CLK);
      OP_VALID <= 1'b1;
      OP_CODE <= op;
      ACC_IN <= a;
      MEM_IN <= m;
      CARRY_IN <= c;
      @(posedge CORE_CLK);
      OP_VALID <= 1'b0;
      #1;
   endtask

   task automatic next_cycle();
      @(posedge CORE_CLK);
      #1;
   endtask

   task automatic t_sbc_acc();
      byte_t       a[4] = '{8'h50, 8'h20, 8'h21, 8'h80};
      byte_t       m[4] = '{8'h20, 8'h20, 8'h20, 8'h01};
      logic        c[4] = '{1'b1, 1'b0, 1'b0, 1'b1};
      logic [11:0] e;
      int          nm;
      nm = n_mem;
      for (int i = 0; i < 4; i++) begin
         e = ref_sub(a[i], m[i], c[i]);
         exec(`OPC_SBC_ACC, a[i], m[i], c[i]);
         `CHK({ACC_WE, MEM_WE, DONE}, 3'h5)
         `CHK(ACC_OUT, e[7:0])
         `CHK({FLAG_WE, C_OUT, Z_OUT, OV_OUT, AC_OUT}, {1'b1, e[11:8]})
         next_cycle();
         `CHK(acc_s, e[7:0])
      end
      `CHK(n_mem, nm)
      $display("test sbc_acc done");
   endtask

   task automatic t_sbc_mem();
      byte_t       a[2] = '{8'h10, 8'h7F};
      byte_t       m[2] = '{8'h01, 8'hFF};
      logic [11:0] e;
      int          na;
      na = n_acc;
      for (int i = 0; i < 2; i++) begin
         e = ref_sub(a[i], m[i], 1'b1);
         exec(`OPC_SBC_MEM, a[i], m[i], 1'b1);
         `CHK({ACC_WE, MEM_WE, DONE}, 3'h3)
         `CHK({FLAG_WE, C_OUT, Z_OUT, OV_OUT, AC_OUT}, {1'b1, e[11:8]})
         next_cycle();
         `CHK(mem_s, e[7:0])
      end
      `CHK(n_acc, na)
      $display("test sbc_mem done");
   endtask

   task automatic t_dec_skip();
      logic [3:0] f;
      int         nf;
      f = {C_OUT, Z_OUT, OV_OUT, AC_OUT};
      nf = n_flag;
      exec(`OPC_DEC_SKIP, 8'h3C, 8'h01, 1'b0);
      `CHK({MEM_WE, SKIP, DONE, FLAG_WE, ACC_WE}, 5'h1C)
      `CHK(MEM_OUT, 8'h00)
      next_cycle();
      `CHK({DUMMY_CYCLE, OP_READY, SKIP}, 3'h4)
      `CHK(mem_s, 8'h00)
      next_cycle();
      `CHK({OP_READY, DUMMY_CYCLE}, 2'h2)
      `CHK({C_OUT, Z_OUT, OV_OUT, AC_OUT}, f)
      `CHK(n_flag, nf)
      $display("test dec_skip done");
   endtask

   task automatic t_dec_noskip();
      byte_t m[2] = '{8'h00, 8'h02};
      int    na;
      na = n_acc;
      for (int i = 0; i < 2; i++) begin
         exec(`OPC_DEC_SKIP, 8'h55, m[i], 1'b1);
         `CHK({MEM_WE, SKIP, DONE, FLAG_WE}, 4'hA)
         `CHK(MEM_OUT, m[i] - 8'h01)
         next_cycle();
         `CHK({OP_READY, DUMMY_CYCLE}, 2'h2)
      end
      `CHK(n_acc, na)
      $display("test dec_noskip done");
   endtask

   task automatic t_skip_refuse();
      int nm;
      nm = n_mem;
      @(posedge CORE_CLK);
      OP_VALID <= 1'b1;
      OP_CODE <= `OPC_DEC_SKIP;
      MEM_IN <= 8'h01;
      // held through the result and dummy slots, both refused
      repeat (3) @(posedge CORE_CLK);
      OP_VALID <= 1'b0;
      #1;
      `CHK({DONE, MEM_WE, DUMMY_CYCLE, OP_READY}, 4'h1)
      `CHK(n_mem, nm + 1)
      $display("test skip_refuse done");
   endtask

   task automatic t_no_op();
      exec(`OPC_NONE, 8'h12, 8'h34, 1'b1);
      `CHK({DONE, ACC_WE, MEM_WE, OP_READY}, 4'h1)
      $display("test no_op done");
   endtask

   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   initial begin
      CORE_CLK = 1'b0;
      forever #50 CORE_CLK = ~CORE_CLK;
   end

   initial begin
      #(2000 * 100);
      fails++;
      end_of_test();
   end

   initial begin
      {RST_N, OP_VALID, CARRY_IN, OP_CODE, ACC_IN, MEM_IN} = '0;
      fails = 0;
      tests_run = 0;
      repeat (10) @(posedge CORE_CLK);
      RST_N <= 1'b1;
      #1;
      `CHK({OP_READY, DONE, ACC_WE, MEM_WE, SKIP}, 5'h10)
      `CHK(ACC_OUT, 8'h00)
      t_sbc_acc();
      t_sbc_mem();
      t_dec_skip();
      t_dec_noskip();
      t_skip_refuse();
      t_no_op();
      end_of_test();
   end
endmodule
